/* File: logic/sep_pkg.sv */
// Shared constants and types of the serial EEPROM slave engine
package sep_pkg;

  // Slave address layout: four fixed prefix bits, three select bits, one direction bit
  localparam logic [3:0] SEP_DEV_PREFIX = 4'hA;
  localparam int SEP_PREFIX_MSB = 7;
  localparam int SEP_PREFIX_LSB = 4;
  localparam int SEP_SEL_MSB = 3;
  localparam int SEP_SEL_LSB = 1;
  localparam int SEP_RW_BIT = 0;

  // Memory geometry: 14 active address bits, 256 pages of 64 bytes
  localparam int SEP_ADDR_W = 14;
  localparam int SEP_OFS_W = 6;
  localparam int SEP_PAGE_BYTES = 64;
  localparam int SEP_MEM_BYTES = 16384;
  localparam int SEP_ADDR_HI_W = 6;
  localparam logic [7:0] SEP_ERASED = 8'hFF;

  // Bit counter positions inside one nine-clock byte slot
  localparam logic [3:0] SEP_BIT_LAST = 4'h7;
  localparam logic [3:0] SEP_BIT_ACK = 4'h8;
  localparam logic [3:0] SEP_BIT_END = 4'h9;

  // Reset value of the SCL and SDA synchronisers (idle bus lines are high)
  localparam logic SEP_LINE_IDLE = 1'b1;

  // Internal programming cycle time and its count in system clocks
  localparam int SEP_SYS_CLK_HZ = 50_000_000;
  localparam int SEP_PROGRAMMING_CYCLE_TIME_US = 5000;
  localparam int SEP_PROG_CYCLES_DEF = SEP_PROGRAMMING_CYCLE_TIME_US * (SEP_SYS_CLK_HZ / 1_000_000);

  // Protocol states of the engine
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DEVADDR,
    ST_ADDRHI,
    ST_ADDRLO,
    ST_WRDATA,
    ST_RDDATA,
    ST_SKIP
  } sep_state_t;

  // Bus events seen in the system clock domain
  typedef struct packed {
    logic start;
    logic stop;
    logic rise;
    logic fall;
    logic bitVal;
  } sep_evt_t;

  // Select pin bundle
  typedef logic [2:0] sep_sel_t;

endpackage

/* File: logic/sep_eeprom_slave.sv */
// Function
// R1: SDA falling with SCL high is START; SDA rising with SCL high is STOP.
// R2: Transmitter keeps SDA stable while SCL is high, except START and STOP.
// R3: A zero pulls SDA low, a one releases it to the pull-up.
// R4: Nothing is answered until a START has been seen.
// R5: Slave address is 1010, three select bits matching the pins, then read/write bit.
// R6: A matching slave address is acknowledged by pulling SDA low on clock nine.
// R7: In writes both address bytes and every data byte are acknowledged.
// R8: Reads shift out a byte, release SDA on clock nine, continue on master ack.
// R9: Master ends a read by not acknowledging the last byte, then STOP.
// R10: Two address bytes load the counter: top 2 ignored, 8 page bits, 6 offset bits.
// R11: Data bytes fill the page buffer; STOP launches the programming cycle.
// R12: During programming SDA stays released and new requests are ignored.
// R13: Slave address is not acknowledged during programming; master may poll.
// R14: Up to 64 bytes of one sequence are programmed in one cycle.
// R15: Page stays latched, offset increments and wraps; later bytes overwrite earlier.
// R16: Only bytes of the latest write sequence are programmed.
// R17: Write protect sampled at the fall before first data; high means nack and discard.
// R18: Every memory byte starts as FFh.
// R19: Read address without address bytes returns the byte at the current counter.
// R20: Random read: write address, two address bytes, new START, read address.
// R21: Sequential reads increment the address and wrap at end of memory.
// R22: Unacknowledged read byte and STOP return the device to idle.
// R23: SDA captured on SCL rise, changed by the transmitter after SCL fall.
// R24: Write protect and select inputs count as low when undriven.
// R25: Programming time is a parameter in core clocks, busy held for all of it.
// R26: After a write the counter points past the last loaded byte, same page.
// R27: Mismatched slave address leaves SDA released until the next START.
`timescale 1ns/1ps
module sep_eeprom_slave #(
  parameter int unsigned PROG_CYCLES = sep_pkg::SEP_PROG_CYCLES_DEF
) (
  // System clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Two-wire link, the serial clock also clocks the capture stage
  input wire logic sclClk,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  // Strap pins
  input wire sep_pkg::sep_sel_t selPins,
  input wire logic wpPin,
  // Status
  output logic progBusy
);
  import sep_pkg::*;

  // One spare count so that the page-size compare never truncates at the shortest legal cycle
  localparam int PCW = $clog2(PROG_CYCLES + 1);

  // Maps a byte and bit slot to the output enable: a zero bit is driven low
  function automatic logic drvLow(input logic [7:0] b, input logic [3:0] idx);
    logic [2:0] pos;
    pos = 3'(SEP_BIT_LAST - idx);
    drvLow = ~b[pos];
  endfunction

  // Link side: capture SDA on each rising serial clock, flag it with a toggle
  logic linkBit_ff = 1'b0;
  logic linkTgl_ff = 1'b0;
  always_ff @(posedge sclClk) begin
    linkBit_ff <= sdaIn; // R23
    linkTgl_ff <= ~linkTgl_ff;
  end

  // Two-stage synchronisers for pins and the capture toggle
  logic [1:0] sclSync_ff;
  logic [1:0] sdaSync_ff;
  logic [1:0] tglSync_ff;
  logic [1:0] wpSync_ff;
  sep_sel_t selSync0_ff;
  sep_sel_t selSync1_ff;
  logic sclDly_ff;
  logic sdaDly_ff;
  logic tglDly_ff;
  logic bitHold_ff;
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      sclSync_ff <= {2{SEP_LINE_IDLE}};
      sdaSync_ff <= {2{SEP_LINE_IDLE}};
      tglSync_ff <= '0;
      wpSync_ff <= '0;
      selSync0_ff <= '0;
      selSync1_ff <= '0;
      sclDly_ff <= SEP_LINE_IDLE;
      sdaDly_ff <= SEP_LINE_IDLE;
      tglDly_ff <= 1'b0;
    end else begin
      sclSync_ff <= {sclSync_ff[0], sclClk};
      sdaSync_ff <= {sdaSync_ff[0], sdaIn};
      tglSync_ff <= {tglSync_ff[0], linkTgl_ff};
      wpSync_ff <= {wpSync_ff[0], wpPin};
      selSync0_ff <= selPins;
      selSync1_ff <= selSync0_ff;
      sclDly_ff <= sclSync_ff[1];
      sdaDly_ff <= sdaSync_ff[1];
      tglDly_ff <= tglSync_ff[1];
    end
  end

  // Captured bit is stable for a whole clock-high period, so it is taken with the toggle
  always_ff @(posedge clk_sys) begin
    bitHold_ff <= linkBit_ff;
  end

  // Bus event decode
  sep_evt_t evt;
  logic sclHi;
  logic sdaNow;
  assign sclHi = sclSync_ff[1];
  assign sdaNow = sdaSync_ff[1];
  assign evt.start = sclHi && sclDly_ff && sdaDly_ff && !sdaNow; // R1
  assign evt.stop = sclHi && sclDly_ff && !sdaDly_ff && sdaNow; // R1
  assign evt.rise = tglSync_ff[1] ^ tglDly_ff;
  assign evt.fall = sclDly_ff && !sclHi;
  assign evt.bitVal = bitHold_ff;

  // Engine state
  sep_state_t state_ff;
  sep_state_t nxt_state;
  logic [3:0] bitCnt_ff;
  logic [3:0] nxt_bitCnt;
  logic [7:0] shift_ff;
  logic [7:0] nxt_shift;
  logic [7:0] txByte_ff;
  logic [7:0] nxt_txByte;
  logic sdaOe_ff;
  logic nxt_sdaOe;
  logic isRead_ff;
  logic nxt_isRead;
  logic mAck_ff;
  logic nxt_mAck;
  logic firstData_ff;
  logic nxt_firstData;
  logic wpLatch_ff;
  logic nxt_wpLatch;
  logic [SEP_ADDR_W-1:0] addrCnt_ff;
  logic [SEP_ADDR_W-1:0] nxt_addrCnt;
  logic busy_ff;
  logic [PCW-1:0] progCnt_ff;
  logic [SEP_PAGE_BYTES-1:0] pageValid_ff;
  logic [7:0] pageBuf [SEP_PAGE_BYTES];
  logic [7:0] memArray [SEP_MEM_BYTES] = '{default: SEP_ERASED}; // R18
  logic bufWr;
  logic clrValid;

  // Slave address and frame decode
  logic inFrame;
  logic addrHit;
  logic launch;
  logic [SEP_OFS_W-1:0] wrOfs;
  logic [SEP_ADDR_W-1:0] rdAddr;
  logic [7:0] rdByte;
  assign inFrame = (state_ff != ST_IDLE) && (state_ff != ST_SKIP); // R4
  assign addrHit = (shift_ff[SEP_PREFIX_MSB:SEP_PREFIX_LSB] == SEP_DEV_PREFIX)
                && (shift_ff[SEP_SEL_MSB:SEP_SEL_LSB] == selSync1_ff); // R5 R24
  assign launch = evt.stop && (state_ff == ST_WRDATA) && (|pageValid_ff); // R11
  assign wrOfs = addrCnt_ff[SEP_OFS_W-1:0];
  assign rdAddr = (state_ff == ST_RDDATA) ? addrCnt_ff + 1'b1 : addrCnt_ff;
  assign rdByte = memArray[rdAddr];

  // Next-state logic of the protocol engine
  always_comb begin
    nxt_state = state_ff;
    nxt_bitCnt = bitCnt_ff;
    nxt_shift = shift_ff;
    nxt_txByte = txByte_ff;
    nxt_sdaOe = sdaOe_ff;
    nxt_isRead = isRead_ff;
    nxt_mAck = mAck_ff;
    nxt_firstData = firstData_ff;
    nxt_wpLatch = wpLatch_ff;
    nxt_addrCnt = addrCnt_ff;
    bufWr = 1'b0;
    clrValid = 1'b0;
    if (evt.start) begin
      nxt_state = ST_DEVADDR; // R1 R4
      nxt_bitCnt = '0;
      nxt_sdaOe = 1'b0;
    end else if (evt.stop) begin
      nxt_state = ST_IDLE; // R22
      nxt_bitCnt = '0;
      nxt_sdaOe = 1'b0;
    end else if (evt.rise && inFrame) begin
      if (bitCnt_ff < SEP_BIT_ACK) begin
        nxt_shift = {shift_ff[6:0], evt.bitVal}; // R23
      end else begin
        nxt_mAck = !evt.bitVal;
      end
      nxt_bitCnt = bitCnt_ff + 4'h1;
    end else if (evt.fall && inFrame) begin
      if (bitCnt_ff == SEP_BIT_ACK) begin
        unique case (state_ff)
          ST_DEVADDR: begin
            if (addrHit && !busy_ff) begin
              nxt_sdaOe = 1'b1; // R6
              nxt_isRead = shift_ff[SEP_RW_BIT];
            end else begin
              nxt_state = ST_SKIP; // R12 R13 R27
            end
          end
          ST_ADDRHI, ST_ADDRLO: begin
            nxt_sdaOe = 1'b1; // R7
          end
          ST_WRDATA: begin
            if (firstData_ff && wpLatch_ff) begin
              nxt_state = ST_SKIP; // R17
            end else begin
              nxt_sdaOe = 1'b1; // R7
              bufWr = 1'b1; // R14
              nxt_firstData = 1'b0;
              nxt_addrCnt = {addrCnt_ff[SEP_ADDR_W-1:SEP_OFS_W], wrOfs + 1'b1}; // R15 R26
            end
          end
          ST_RDDATA: begin
            nxt_sdaOe = 1'b0; // R8
          end
          default: begin
            nxt_sdaOe = 1'b0;
          end
        endcase
      end else if (bitCnt_ff == SEP_BIT_END) begin
        nxt_bitCnt = '0;
        nxt_sdaOe = 1'b0;
        unique case (state_ff)
          ST_DEVADDR: begin
            if (isRead_ff) begin
              nxt_state = ST_RDDATA; // R19 R20
              nxt_txByte = rdByte;
              nxt_sdaOe = drvLow(rdByte, '0); // R3
            end else begin
              nxt_state = ST_ADDRHI;
            end
          end
          ST_ADDRHI: begin
            nxt_state = ST_ADDRLO;
            nxt_addrCnt = {shift_ff[SEP_ADDR_HI_W-1:0], addrCnt_ff[7:0]}; // R10
          end
          ST_ADDRLO: begin
            nxt_state = ST_WRDATA;
            nxt_addrCnt = {addrCnt_ff[SEP_ADDR_W-1:8], shift_ff}; // R10 R20
            nxt_firstData = 1'b1;
            nxt_wpLatch = wpSync_ff[1]; // R17
            clrValid = 1'b1; // R16
          end
          ST_WRDATA: begin
            nxt_state = ST_WRDATA;
          end
          ST_RDDATA: begin
            nxt_addrCnt = addrCnt_ff + 1'b1; // R21
            if (mAck_ff) begin
              nxt_txByte = rdByte; // R8
              nxt_sdaOe = drvLow(rdByte, '0); // R3
            end else begin
              nxt_state = ST_SKIP; // R9 R22
            end
          end
          default: begin
            nxt_state = ST_SKIP;
          end
        endcase
      end else if (state_ff == ST_RDDATA) begin
        nxt_sdaOe = drvLow(txByte_ff, bitCnt_ff); // R2 R3 R23
      end
    end
  end

  // Engine registers
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      state_ff <= ST_IDLE;
      bitCnt_ff <= '0;
      shift_ff <= '0;
      txByte_ff <= '0;
      sdaOe_ff <= 1'b0;
      isRead_ff <= 1'b0;
      mAck_ff <= 1'b0;
      firstData_ff <= 1'b0;
      wpLatch_ff <= 1'b0;
      addrCnt_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      bitCnt_ff <= nxt_bitCnt;
      shift_ff <= nxt_shift;
      txByte_ff <= nxt_txByte;
      sdaOe_ff <= nxt_sdaOe;
      isRead_ff <= nxt_isRead;
      mAck_ff <= nxt_mAck;
      firstData_ff <= nxt_firstData;
      wpLatch_ff <= nxt_wpLatch;
      addrCnt_ff <= nxt_addrCnt;
    end
  end

  // Page buffer data, overwritten in place when the offset wraps
  always_ff @(posedge clk_sys) begin
    if (bufWr) begin
      pageBuf[wrOfs] <= shift_ff; // R15
    end
  end

  // Valid marks: a new sequence forgets bytes of earlier ones
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      pageValid_ff <= '0;
    end else if (clrValid) begin
      pageValid_ff <= '0; // R16
    end else if (bufWr) begin
      pageValid_ff[wrOfs] <= 1'b1;
    end
  end

  // Programming cycle timer, busy for exactly PROG_CYCLES clocks
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      busy_ff <= 1'b0;
      progCnt_ff <= '0;
    end else if (launch && !busy_ff) begin
      busy_ff <= 1'b1; // R11 R25
      progCnt_ff <= '0;
    end else if (busy_ff) begin
      if (progCnt_ff == PCW'(PROG_CYCLES - 1)) begin
        busy_ff <= 1'b0; // R25
      end
      progCnt_ff <= progCnt_ff + 1'b1;
    end
  end

  // Commit one valid buffered byte per clock at the start of the cycle
  logic [SEP_OFS_W-1:0] commitIdx;
  logic commitEn;
  assign commitIdx = progCnt_ff[SEP_OFS_W-1:0];
  assign commitEn = busy_ff && (progCnt_ff < PCW'(SEP_PAGE_BYTES)) && pageValid_ff[commitIdx]; // R14 R16
  always_ff @(posedge clk_sys) begin
    if (commitEn) begin
      memArray[{addrCnt_ff[SEP_ADDR_W-1:SEP_OFS_W], commitIdx}] <= pageBuf[commitIdx]; // R11
    end
  end

  // Open-drain output: only ever pulls low
  assign sdaOut = 1'b0; // R3
  assign sdaOe = sdaOe_ff;
  assign progBusy = busy_ff;

  // Checks on the engine
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  property p_start_enters_addr;
    evt.start |=> (state_ff == ST_DEVADDR) && (bitCnt_ff == 4'h0) && !sdaOe_ff;
  endproperty
  a_start_enters_addr: assert property (p_start_enters_addr) else $error("START not taken"); // R1

  property p_drive_on_fall;
    $rose(sdaOe_ff) |-> $past(evt.fall);
  endproperty
  a_drive_on_fall: assert property (p_drive_on_fall) else $error("SDA driven outside SCL low"); // R2

  property p_idle_quiet;
    (state_ff == ST_IDLE) || (state_ff == ST_SKIP) |-> !sdaOe_ff;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("SDA driven while idle"); // R4

  property p_addr_ack;
    evt.fall && !evt.start && !evt.stop && (state_ff == ST_DEVADDR) && (bitCnt_ff == SEP_BIT_ACK)
      && addrHit && !busy_ff |=> sdaOe_ff ##1 sdaOe_ff;
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("Address not acknowledged"); // R6

  property p_busy_nack;
    busy_ff && evt.fall && !evt.start && !evt.stop && (state_ff == ST_DEVADDR)
      && (bitCnt_ff == SEP_BIT_ACK) |=> !sdaOe_ff && (state_ff == ST_SKIP);
  endproperty
  a_busy_nack: assert property (p_busy_nack) else $error("Address acknowledged while busy"); // R13

  property p_wp_nack;
    evt.fall && !evt.start && !evt.stop && (state_ff == ST_WRDATA) && (bitCnt_ff == SEP_BIT_ACK)
      && firstData_ff && wpLatch_ff |=> !sdaOe_ff && (state_ff == ST_SKIP) && (pageValid_ff == '0);
  endproperty
  a_wp_nack: assert property (p_wp_nack) else $error("Protected write accepted"); // R17

  property p_page_wrap;
    bufWr |=> (addrCnt_ff[SEP_ADDR_W-1:SEP_OFS_W] == $past(addrCnt_ff[SEP_ADDR_W-1:SEP_OFS_W]))
      && (addrCnt_ff[SEP_OFS_W-1:0] == $past(addrCnt_ff[SEP_OFS_W-1:0]) + 1'b1);
  endproperty
  a_page_wrap: assert property (p_page_wrap) else $error("Page offset did not wrap in page"); // R15

  property p_read_advance;
    evt.fall && !evt.start && !evt.stop && (state_ff == ST_RDDATA) && (bitCnt_ff == SEP_BIT_END)
      |=> addrCnt_ff == $past(addrCnt_ff) + 1'b1;
  endproperty
  a_read_advance: assert property (p_read_advance) else $error("Read address did not advance"); // R21

  property p_busy_hold;
    $rose(busy_ff) |-> busy_ff [*8];
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("Busy dropped early"); // R25

  property p_busy_len;
    $fell(busy_ff) |-> $past(progCnt_ff) == PCW'(PROG_CYCLES - 1);
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("Busy length wrong"); // R25

  c_page_write: cover property (launch && !busy_ff);
  c_seq_read: cover property ((state_ff == ST_RDDATA) && evt.fall && (bitCnt_ff == SEP_BIT_END) && mAck_ff);
  c_poll_nack: cover property (busy_ff && (state_ff == ST_SKIP));
  c_wp_reject: cover property (firstData_ff && wpLatch_ff && (state_ff == ST_SKIP));

endmodule

/* File: sim/sep_bus_master.sv */
`timescale 1ns/1ps
module sep_bus_master (
  // Resolved data wire
  input wire logic sdaLine,
  // Link clock and data pull-down
  output logic sclClk,
  output logic mstOe
);
  localparam time Q = 15ns;

  // Bus idles with clock high and data released
  initial begin
    sclClk = 1'b1;
    mstOe = 1'b0;
  end

  // One clock: data changes mid-low, sampled mid-high, never moves while high
  task automatic bitCycle(input logic txBit, output logic rxBit);
    sclClk = 1'b0;
    #(8*Q);
    mstOe = ~txBit;
    #(8*Q);
    sclClk = 1'b1;
    #(8*Q);
    rxBit = sdaLine;
    #(8*Q);
  endtask

  // Start, also used as a repeated start
  task automatic startCond();
    sclClk = 1'b0;
    #(8*Q);
    mstOe = 1'b0;
    #(8*Q);
    sclClk = 1'b1;
    #(16*Q);
    mstOe = 1'b1;
    #(16*Q);
  endtask

  // Stop, clock then stands high
  task automatic stopCond();
    sclClk = 1'b0;
    #(8*Q);
    mstOe = 1'b1;
    #(8*Q);
    sclClk = 1'b1;
    #(16*Q);
    mstOe = 1'b0;
    #(16*Q);
  endtask

  // Byte out MSB first, ninth clock returns the slave answer
  task automatic sendByte(input logic [7:0] txByte, output logic ackBit);
    logic unused;
    for (int i = 7; i >= 0; i--) begin
      bitCycle(txByte[i], unused);
    end
    bitCycle(1'b1, ackBit);
  endtask

  // Byte in, then master ack or not-acknowledge
  task automatic recvByte(input logic giveAck, output logic [7:0] rxByte);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bitCycle(1'b1, b);
      rxByte[i] = b;
    end
    bitCycle(~giveAck, b);
  endtask
endmodule

/* File: sim/sep_eeprom_slave_bench.sv */
`timescale 1ns/1ps
module sep_eeprom_slave_bench;
  import sep_pkg::*;
  localparam int PROG_N = 1000;
  localparam int WATCH_N = 90000;
  logic clk_sys;
  logic nrst;
  logic sclClk;
  logic mstOe;
  logic sdaOe;
  logic sdaOut;
  logic sdaLine;
  logic progBusy;
  logic wpPin;
  sep_sel_t selPins;
  int fails;
  int check_count;
  int seedVal;
  logic [7:0] memModel [SEP_MEM_BYTES];
  logic [SEP_ADDR_W-1:0] curAddr;
  logic [SEP_ADDR_W-1:0] a;
  logic ack;
  logic [7:0] rdData;

  // Open-drain wire with pull-up
  assign sdaLine = ~mstOe & (sdaOe ? sdaOut : 1'b1);

  sep_eeprom_slave #(.PROG_CYCLES(PROG_N)) dut_u (.clk_sys(clk_sys), .nrst(nrst), .sclClk(sclClk),
    .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe), .selPins(selPins), .wpPin(wpPin), .progBusy(progBusy));
  sep_bus_master mst_u (.sdaLine(sdaLine), .sclClk(sclClk), .mstOe(mstOe));

  // System clock
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic final_report();
    $display("Checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic cmpBit(input logic expV, input logic gotV);
    check_count++;
    if (gotV !== expV) begin
      fails++;
      $display("[ERR] %0t exp %0h got %0h", $time, expV, gotV);
    end
  endtask

  task automatic cmpByte(input logic [7:0] expV, input logic [7:0] gotV);
    check_count++;
    if (gotV !== expV) begin
      fails++;
      $display("[ERR] %0t exp %0h got %0h", $time, expV, gotV);
    end
  endtask

  // Slave address byte for this run's straps
  function automatic logic [7:0] devByte(input logic rd);
    return {SEP_DEV_PREFIX, selPins, rd};
  endfunction

  // Start, write address, two address bytes with random ignored top bits
  task automatic setAddr(input logic [SEP_ADDR_W-1:0] adr);
    logic [1:0] junk;
    junk = 2'($urandom);
    mst_u.startCond();
    mst_u.sendByte(devByte(1'b0), ack);
    cmpBit(1'b0, ack);
    mst_u.sendByte({junk, adr[13:8]}, ack);
    cmpBit(1'b0, ack);
    mst_u.sendByte(adr[7:0], ack);
    cmpBit(1'b0, ack);
    curAddr = adr;
  endtask

  // Read n bytes from the counter, not-acknowledge on the last one
  task automatic readOn(input int n);
    mst_u.startCond();
    mst_u.sendByte(devByte(1'b1), ack);
    cmpBit(1'b0, ack);
    for (int i = 0; i < n; i++) begin
      mst_u.recvByte(i < n - 1, rdData);
      cmpByte(memModel[curAddr], rdData);
      curAddr = curAddr + 1'b1;
    end
    mst_u.stopCond();
  endtask

  // Page write with optional protect, then busy polling when unprotected
  task automatic writeSeq(input logic [SEP_ADDR_W-1:0] adr, input int n, input logic prot);
    logic [7:0] d;
    logic [SEP_OFS_W-1:0] ofs;
    ofs = adr[5:0];
    @(posedge clk_sys);
    #1 wpPin = prot;
    setAddr(adr);
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      mst_u.sendByte(d, ack);
      cmpBit(prot, ack);
      if (prot) break;
      memModel[{adr[13:6], ofs}] = d;
      ofs = ofs + 1'b1;
    end
    mst_u.stopCond();
    if (!prot) curAddr = {adr[13:6], ofs};
    repeat (20) @(posedge clk_sys);
    cmpBit(~prot, progBusy);
    if (!prot) begin
      mst_u.startCond();
      mst_u.sendByte(devByte(1'b1), ack);
      cmpBit(1'b1, ack);
      mst_u.stopCond();
      for (int k = 0; k < 3 * PROG_N && progBusy !== 1'b0; k++) @(posedge clk_sys);
      cmpBit(1'b0, progBusy);
    end
    #1 wpPin = 1'b0;
  endtask

  // Hang guard
  initial begin
    repeat (WATCH_N) @(posedge clk_sys);
    fails++;
    final_report();
  end

  // Main sequence
  initial begin
    nrst = 1'b0;
    wpPin = 1'b0;
    fails = 0;
    check_count = 0;
    seedVal = $urandom(129);
    selPins = 3'($urandom);
    for (int i = 0; i < SEP_MEM_BYTES; i++) memModel[i] = SEP_ERASED;
    repeat (2) @(posedge clk_sys);
    #1 nrst = 1'b1;
    repeat (4) @(posedge clk_sys);
    // Address byte without a start
    mst_u.sendByte(devByte(1'b0), ack);
    cmpBit(1'b1, ack);
    mst_u.stopCond();
    // Wrong select bits, then wrong prefix
    mst_u.startCond();
    mst_u.sendByte({SEP_DEV_PREFIX, selPins ^ 3'h1, 1'b0}, ack);
    cmpBit(1'b1, ack);
    mst_u.sendByte(8'h00, ack);
    cmpBit(1'b1, ack);
    mst_u.startCond();
    mst_u.sendByte({4'h5, selPins, 1'b1}, ack);
    cmpBit(1'b1, ack);
    mst_u.stopCond();
    // Erased random read
    setAddr(14'($urandom));
    readOn(3);
    // Page write past the page end, current read, page readback
    a = 14'($urandom);
    writeSeq(a, 70, 1'b0);
    readOn(1);
    setAddr({a[13:6], 6'h00});
    readOn(64);
    // Protected write leaves memory alone
    writeSeq(a, 1, 1'b1);
    setAddr(a);
    readOn(1);
    // Bytes dropped by a repeated start never reach memory
    a = 14'($urandom);
    setAddr({a[13:6], 6'h00});
    for (int i = 0; i < 3; i++) mst_u.sendByte(8'($urandom), ack);
    writeSeq({a[13:6], 6'h00}, 1, 1'b0);
    setAddr({a[13:6], 6'h00});
    readOn(4);
    // Sequential read wraps at the end of memory
    writeSeq(14'h3FFF, 1, 1'b0);
    setAddr(14'h3FFE);
    readOn(3);
    // Random short writes with readback
    for (int t = 0; t < 3; t++) begin
      a = 14'($urandom);
      writeSeq(a, 1 + $urandom % 4, 1'b0);
      readOn(1);
      setAddr(a);
      readOn(4);
    end
    final_report();
  end
endmodule
